// ---- design/burst_link_if.sv ----
// link between the memory controller and the burst static memory port
interface burst_link_if #(
	parameter int DW = burst_sram_pkg::DEF_DW,
	parameter int AW = burst_sram_pkg::DEF_AW
);
	localparam int LANES = DW / burst_sram_pkg::LANE_W; // lane count
	logic k_true; // 1: this cycle is a true-clock edge, 0: complementary
	logic rd_n; // read select, active low
	logic wr_n; // write select, active low
	logic [AW-1:0] addr; // external word-pair address
	logic [DW-1:0] d; // write data beat
	logic [LANES-1:0] lane_store_n; // per-lane store enable, active low
	logic oclk_run; // 1: output clock pair runs, 0: held high
	logic [DW-1:0] q; // read data beat
	logic q_oe; // read data driven
	logic q_edge_true; // output true-clock strobe with beat
	logic q_edge_comp; // output complementary-clock strobe with beat
	// memory end
	modport mem (
		input k_true, rd_n, wr_n, addr, d, lane_store_n, oclk_run,
		output q, q_oe, q_edge_true, q_edge_comp
	);
	// controller end
	modport ctrl (
		output k_true, rd_n, wr_n, addr, d, lane_store_n, oclk_run,
		input q, q_oe, q_edge_true, q_edge_comp
	);
endinterface

// ---- design/burst_sram_ctrl.sv ----
// controller end: issues bursts, buffers read beats for the user
module burst_sram_ctrl #(
	parameter int DW = burst_sram_pkg::DEF_DW,
	parameter int AW = burst_sram_pkg::DEF_AW
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	burst_link_if.ctrl link, // memory link
	input wire logic i_oclk_run, // 1: output clocks run, 0: held high
	input wire logic i_cmd_valid, // command offered
	input wire logic i_cmd_write, // 1 write, 0 read
	input wire logic [AW-1:0] i_cmd_addr, // word-pair address
	input wire logic [DW-1:0] i_wdata0, // first write beat
	input wire logic [DW-1:0] i_wdata1, // second write beat
	input wire logic [DW/burst_sram_pkg::LANE_W-1:0] i_lanes0_n, // beat 0 lane enables
	input wire logic [DW/burst_sram_pkg::LANE_W-1:0] i_lanes1_n, // beat 1 lane enables
	output logic o_cmd_ready, // command taken when valid
	output logic [DW-1:0] o_rdata, // read beat to user
	output logic o_rdata_valid, // read beat present
	input wire logic i_rdata_ready // user takes read beat
);
	localparam int LANES = DW / burst_sram_pkg::LANE_W; // lane count

	if (DW != LANES * burst_sram_pkg::LANE_W || !(LANES == 1 || LANES == 2 || LANES == 4))
		$error("data width must be 9, 18 or 36");

	// whole state of the controller end
	typedef struct packed {
		logic kt; // true-edge phase driven on the link
		logic rd_n; // read select
		logic wr_n; // write select
		logic [AW-1:0] addr; // link address
		logic [DW-1:0] d; // link write beat
		logic [LANES-1:0] ln; // link lane enables
		logic oclk; // output clock run flag
		logic wph; // second write beat due
		logic [DW-1:0] pd; // held second beat
		logic [LANES-1:0] pl; // held second lane enables
		logic infl; // read burst outstanding
		logic [1:0] rb; // read beats received
		logic v0; // buffer head valid
		logic v1; // buffer tail valid
		logic [DW-1:0] s0; // buffer head
		logic [DW-1:0] s1; // buffer tail
		logic rdy; // command ready
	} ctrl_state_t;

	ctrl_state_t st_r; // registered state
	ctrl_state_t st_nxt; // next state

	// next-state logic
	always_comb begin
		logic take;
		logic pop;
		take = o_cmd_ready && i_cmd_valid;
		pop = st_r.v0 && i_rdata_ready;
		st_nxt = st_r;
		st_nxt.kt = !st_r.kt;
		st_nxt.oclk = i_oclk_run;
		st_nxt.rd_n = burst_sram_pkg::SEL_OFF;
		st_nxt.wr_n = burst_sram_pkg::SEL_OFF;
		st_nxt.d = '0;
		st_nxt.ln = '1;
		st_nxt.wph = 1'b0;
		// second write beat on the complementary edge
		if (st_r.wph) begin // RL12
			st_nxt.d = st_r.pd;
			st_nxt.ln = st_r.pl; // RL5
		end
		// new command lands on the coming true edge
		if (take) begin // RL10 RL11
			st_nxt.addr = i_cmd_addr;
			if (i_cmd_write) begin
				st_nxt.wr_n = burst_sram_pkg::SEL_ON;
				st_nxt.d = i_wdata0;
				st_nxt.ln = i_lanes0_n; // RL1 RL2 RL3
				st_nxt.pd = i_wdata1;
				st_nxt.pl = i_lanes1_n;
				st_nxt.wph = 1'b1;
			end else begin
				st_nxt.rd_n = burst_sram_pkg::SEL_ON;
				st_nxt.infl = 1'b1;
				st_nxt.rb = burst_sram_pkg::CNT_ZERO;
			end
		end
		// two-entry buffer: head shifts forward on pop
		if (pop) begin
			st_nxt.v0 = st_r.v1;
			st_nxt.s0 = st_r.s1;
			st_nxt.v1 = 1'b0;
		end
		// capture returning beats; room was reserved before issue
		if (link.q_oe) begin // RL13
			if (!st_nxt.v0) begin
				st_nxt.v0 = 1'b1;
				st_nxt.s0 = link.q;
			end else begin
				st_nxt.v1 = 1'b1;
				st_nxt.s1 = link.q;
			end
			st_nxt.rb = st_r.rb + burst_sram_pkg::CNT_ONE;
			if (st_nxt.rb == burst_sram_pkg::BURST_LEN) begin // RL8
				st_nxt.infl = 1'b0;
			end
		end
		// ready only ahead of a true edge and with the buffer empty
		st_nxt.rdy = st_r.kt && !st_nxt.infl && !st_nxt.v0 && !st_nxt.v1;
	end

	// state register
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
			st_r.rd_n <= burst_sram_pkg::SEL_OFF;
			st_r.wr_n <= burst_sram_pkg::SEL_OFF;
			st_r.ln <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign link.k_true = st_r.kt;
	assign link.rd_n = st_r.rd_n;
	assign link.wr_n = st_r.wr_n;
	assign link.addr = st_r.addr;
	assign link.d = st_r.d;
	assign link.lane_store_n = st_r.ln;
	assign link.oclk_run = st_r.oclk;
	assign o_cmd_ready = st_r.rdy;
	assign o_rdata = st_r.s0;
	assign o_rdata_valid = st_r.v0;
endmodule

// ---- design/burst_sram_mem.sv ----
// memory end: burst write with lane masks, burst read pipeline
module burst_sram_mem #(
	parameter int DW = burst_sram_pkg::DEF_DW,
	parameter int AW = burst_sram_pkg::DEF_AW
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	burst_link_if.mem link, // controller link
	output logic o_wr_busy, // write burst in progress
	output logic o_rd_busy // read burst in progress
);
	localparam int LANES = DW / burst_sram_pkg::LANE_W; // lane count
	localparam int IAW = AW + 1; // internal address width
	localparam int DEPTH = 1 << IAW; // words held

	// refuse organisations the lane logic cannot serve
	if (DW != LANES * burst_sram_pkg::LANE_W || !(LANES == 1 || LANES == 2 || LANES == 4))
		$error("data width must be 9, 18 or 36");
	if (AW < 1)
		$error("address width must be at least 1");

	// whole state of the memory end
	typedef struct packed {
		burst_sram_pkg::wr_state_t ws; // write machine
		logic [1:0] wcnt; // write beat counter
		logic [AW-1:0] waddr; // captured write address
		burst_sram_pkg::rd_state_t rs; // read machine
		logic [1:0] rcnt; // read beat counter
		logic [AW-1:0] raddr; // address of burst being sent
		logic [burst_sram_pkg::RD_PIPE-1:0] dv; // read load delay valids
		logic [burst_sram_pkg::RD_PIPE-1:0][AW-1:0] da; // delayed addresses
		logic [DW-1:0] q; // read data register
		logic q_oe; // read data enable
		logic qt; // true output strobe
		logic qc; // complementary output strobe
		logic wbusy; // write busy flag
		logic rbusy; // read busy flag
		logic [DEPTH-1:0][DW-1:0] mem; // storage array
	} mem_state_t;

	mem_state_t st_r; // registered state
	mem_state_t st_nxt; // next state

	// commands count only on a true-clock edge
	logic wr_go; // write load this edge
	logic rd_go; // read load this edge
	assign wr_go = link.k_true && (link.wr_n == burst_sram_pkg::SEL_ON); // RL10 RL11
	assign rd_go = link.k_true && (link.rd_n == burst_sram_pkg::SEL_ON); // RL10 RL11

	// lane-masked merge of one beat into a stored word
	function automatic logic [DW-1:0] merge_lanes(
		input logic [DW-1:0] old_w,
		input logic [DW-1:0] new_w,
		input logic [LANES-1:0] store_n
	);
		logic [DW-1:0] res;
		res = old_w;
		for (int i = 0; i < LANES; i++) begin
			// low enable stores the nine bits of that lane
			if (!store_n[i]) begin
				res[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
					new_w[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W]; // RL1 RL2 RL3 RL5
			end
		end
		return res;
	endfunction

	// next-state logic for both machines
	always_comb begin
		logic [IAW-1:0] wa;
		logic [IAW-1:0] ra;
		wa = '0;
		ra = '0;
		st_nxt = st_r;
		// read data floats unless a beat is launched below
		st_nxt.q = '0;
		st_nxt.q_oe = 1'b0;
		st_nxt.qt = 1'b0;
		st_nxt.qc = 1'b0;

		// write machine, independent of the read machine
		unique case (st_r.ws)
			burst_sram_pkg::W_IDLE: begin
				// lane enables outside a burst fall through unused
				if (wr_go) begin // RL4
					wa = {link.addr, burst_sram_pkg::BEAT0_OFS}; // RL6 RL7
					st_nxt.mem[wa] = merge_lanes(st_r.mem[wa], link.d, link.lane_store_n); // RL12
					st_nxt.waddr = link.addr;
					st_nxt.wcnt = burst_sram_pkg::CNT_ONE;
					st_nxt.ws = burst_sram_pkg::W_BEAT1;
					st_nxt.wbusy = 1'b1;
				end
			end
			burst_sram_pkg::W_BEAT1: begin
				// second beat arrives on the complementary edge
				wa = {st_r.waddr, burst_sram_pkg::BEAT1_OFS}; // RL6 RL7
				st_nxt.mem[wa] = merge_lanes(st_r.mem[wa], link.d, link.lane_store_n); // RL5 RL12
				st_nxt.wcnt = st_r.wcnt + burst_sram_pkg::CNT_ONE;
				// count hits two: the bus cycle is over
				if (st_nxt.wcnt == burst_sram_pkg::BURST_LEN) begin // RL8
					st_nxt.ws = burst_sram_pkg::W_IDLE;
					st_nxt.wcnt = burst_sram_pkg::CNT_ZERO;
					st_nxt.wbusy = 1'b0;
				end
			end
		endcase

		// read load delay line, one stage per edge
		st_nxt.dv = {st_r.dv[0], rd_go}; // RL13
		st_nxt.da = {st_r.da[0], link.addr};

		// read machine, free of the write machine
		unique case (st_r.rs)
			burst_sram_pkg::R_IDLE: begin
				// launch first beat at the complementary edge of t+1
				if (st_r.dv[burst_sram_pkg::RD_PIPE-1]) begin // RL9 RL13
					ra = {st_r.da[burst_sram_pkg::RD_PIPE-1], burst_sram_pkg::BEAT0_OFS}; // RL7
					st_nxt.q = st_r.mem[ra];
					st_nxt.q_oe = 1'b1;
					// with output clocks held the beat rides the input edge only
					st_nxt.qc = link.oclk_run; // RL14
					st_nxt.raddr = st_r.da[burst_sram_pkg::RD_PIPE-1];
					st_nxt.rcnt = burst_sram_pkg::CNT_ONE;
					st_nxt.rs = burst_sram_pkg::R_BEAT1;
					st_nxt.rbusy = 1'b1;
				end
			end
			burst_sram_pkg::R_BEAT1: begin
				// second beat at the true edge of t+2
				ra = {st_r.raddr, burst_sram_pkg::BEAT1_OFS}; // RL6 RL7 RL13
				st_nxt.q = st_r.mem[ra];
				st_nxt.q_oe = 1'b1;
				st_nxt.qt = link.oclk_run; // RL14
				st_nxt.rcnt = st_r.rcnt + burst_sram_pkg::CNT_ONE;
				if (st_nxt.rcnt == burst_sram_pkg::BURST_LEN) begin // RL8
					st_nxt.rs = burst_sram_pkg::R_IDLE;
					st_nxt.rcnt = burst_sram_pkg::CNT_ZERO;
					st_nxt.rbusy = 1'b0;
				end
			end
		endcase
	end

	// state register; storage is cleared too so reads are never unknown
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin // RL10
		if (!i_rst_n) begin
			st_r <= '0;
			st_r.ws <= burst_sram_pkg::W_IDLE;
			st_r.rs <= burst_sram_pkg::R_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign link.q = st_r.q;
	assign link.q_oe = st_r.q_oe; // RL11
	assign link.q_edge_true = st_r.qt;
	assign link.q_edge_comp = st_r.qc;
	assign o_wr_busy = st_r.wbusy;
	assign o_rd_busy = st_r.rbusy;
endmodule

// ---- design/burst_sram_pkg.sv ----
// constants, encodings and state types shared by both ends of the burst link
// Behaviour
// RL1: one lane: enable low stores all nine bits
// RL2: two lanes: each low enable stores nine bits
// RL3: four lanes: any mix, all high stores nothing
// RL4: lane enables ignored outside a write burst
// RL5: lane enables may change between beats
// RL6: address gets one extra internal low bit
// RL7: beat order fixed: offset zero then one
// RL8: every burst ends after exactly two beats
// RL9: read and write machines run independently
// RL10: sequencing advances on true input clock
// RL11: active-low selects sampled on true edge only
// RL12: write beats on true then complementary edge
// RL13: read beats three and four edges later
// RL14: held output clocks: time data from input
package burst_sram_pkg;
	localparam int LANE_W = 9; // bits per byte lane
	localparam int DEF_DW = 36; // default data width
	localparam int DEF_AW = 4; // default external address width
	localparam logic [1:0] BURST_LEN = 2'h2; // beats per bus cycle
	localparam logic [1:0] CNT_ZERO = 2'h0; // burst counter start
	localparam logic [1:0] CNT_ONE = 2'h1; // one beat done
	localparam logic BEAT0_OFS = 1'h0; // first beat offset
	localparam logic BEAT1_OFS = 1'h1; // second beat offset
	localparam int RD_PIPE = 2; // load-to-launch stages of a read
	localparam logic SEL_ON = 1'h0; // active-low select asserted
	localparam logic SEL_OFF = 1'h1; // select idle
	// write machine states
	typedef enum logic [1:0] {
		W_IDLE = 2'h1,
		W_BEAT1 = 2'h2
	} wr_state_t;
	// read machine states
	typedef enum logic [1:0] {
		R_IDLE = 2'h1,
		R_BEAT1 = 2'h2
	} rd_state_t;
endpackage

// ---- test/burst_byte_write_sram_port_bench.sv ----
// self-checking bench: controller and memory ends joined by the link
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
	$display("FAIL %s expected %h seen %h", nm, ex, got); end end
module burst_byte_write_sram_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'h0; // 8 ns clock
	logic rst_n = 1'h0; // reset, active low
	logic oclk_run = 1'h1; // output clocks run
	logic cmd_valid = 1'h0; // command offered
	logic cmd_write = 1'h0; // write or read
	logic [3:0] cmd_addr = 4'h0; // word-pair address
	logic [35:0] wdata0 = 36'h0; // first beat
	logic [35:0] wdata1 = 36'h0; // second beat
	logic [3:0] lanes0_n = 4'hf; // beat0 lanes
	logic [3:0] lanes1_n = 4'hf; // beat1 lanes
	logic rdata_ready = 1'h0; // user pops read beats
	logic cmd_ready; // command taken
	logic [35:0] rdata; // read beat
	logic rdata_valid; // read beat present
	logic wr_busy; // write burst in progress
	logic rd_busy; // read burst in progress
	int errors = 0; // mismatches
	int compares = 0; // comparisons made
	int cyc = 0; // cycles for the hang guard
	logic [35:0] exp_mem [32]; // expected array, index {addr, beat}
	burst_link_if link (); // default organisation: 36 bits, four lanes
	burst_sram_mem #(.DW(36), .AW(4)) burst_sram_mem_inst (.i_sys_clk(sys_clk),
		.i_rst_n(rst_n), .link(link), .o_wr_busy(wr_busy), .o_rd_busy(rd_busy));
	burst_sram_ctrl #(.DW(36), .AW(4)) burst_sram_ctrl_inst (.i_sys_clk(sys_clk),
		.i_rst_n(rst_n), .link(link), .i_oclk_run(oclk_run), .i_cmd_valid(cmd_valid),
		.i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_wdata0(wdata0),
		.i_wdata1(wdata1), .i_lanes0_n(lanes0_n), .i_lanes1_n(lanes1_n),
		.o_cmd_ready(cmd_ready), .o_rdata(rdata), .o_rdata_valid(rdata_valid),
		.i_rdata_ready(rdata_ready));
	burst_link_monitor burst_link_monitor_inst (.i_sys_clk(sys_clk),
		.i_rst_n(rst_n), .k_true(link.k_true), .rd_n(link.rd_n), .wr_n(link.wr_n),
		.addr(link.addr), .d(link.d), .lane_store_n(link.lane_store_n),
		.oclk_run(link.oclk_run), .q(link.q), .q_oe(link.q_oe),
		.q_edge_true(link.q_edge_true), .q_edge_comp(link.q_edge_comp));
	// clock
	always #4 sys_clk = ~sys_clk;
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			finish_test();
		end
	end
	// only low enables copy their nine bits
	function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
		for (int j = 0; j < 4; j++) if (!m[j]) o[j*9 +: 9] = n[j*9 +: 9];
		return o;
	endfunction
	// offer one command, hold it until ready is seen at an edge
	task automatic cmd(input logic w, input logic [3:0] a, input logic [35:0] d0, d1,
		input logic [3:0] l0, l1);
		@(posedge sys_clk);
		#1;
		cmd_write = w;
		cmd_addr = a;
		wdata0 = d0;
		wdata1 = d1;
		lanes0_n = l0;
		lanes1_n = l1;
		cmd_valid = 1'h1;
		@(negedge sys_clk);
		while (cmd_ready !== 1'h1) @(negedge sys_clk);
		@(posedge sys_clk);
		#1 cmd_valid = 1'h0;
	endtask
	// write burst and its effect on the expected array
	task automatic wr(input logic [3:0] a, input logic [35:0] d0, d1, input logic [3:0] l0, l1);
		cmd(1'h1, a, d0, d1, l0, l1);
		exp_mem[{a, 1'h0}] = merge(exp_mem[{a, 1'h0}], d0, l0);
		exp_mem[{a, 1'h1}] = merge(exp_mem[{a, 1'h1}], d1, l1);
		// busy only in the beat-one cycle, then the burst is over
		@(negedge sys_clk);
		@(negedge sys_clk);
		`CHK("wr_busy", 1'h1, wr_busy)
		@(negedge sys_clk);
		`CHK("wr_busy", 1'h0, wr_busy)
	endtask
	// read burst; the user stalls so both beats sit in the buffer first
	task automatic rd(input logic [3:0] a);
		cmd(1'h0, a, 36'h0, 36'h0, 4'hf, 4'hf);
		// read machine busy for one cycle, with the first beat on the link
		repeat (4) @(negedge sys_clk);
		`CHK("rd_busy", 1'h1, rd_busy)
		@(negedge sys_clk);
		`CHK("rd_busy", 1'h0, rd_busy)
		repeat (2) @(posedge sys_clk);
		#1 rdata_ready = 1'h1;
		for (int b = 0; b < 2; b++) begin
			@(negedge sys_clk);
			while (rdata_valid !== 1'h1) @(negedge sys_clk);
			`CHK("rdata", exp_mem[{a, b[0]}], rdata)
			@(posedge sys_clk);
		end
		#1 rdata_ready = 1'h0;
	endtask
	// reset held 8 cycles; the array is cleared with it
	task automatic do_reset();
		@(posedge sys_clk);
		#1 rst_n = 1'h0;
		foreach (exp_mem[i]) exp_mem[i] = 36'h0;
		repeat (8) @(posedge sys_clk);
		#1 rst_n = 1'h1;
	endtask
	task automatic finish_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// test sequence
	initial begin
		do_reset();
		wr(4'h3, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
		// every lane mix, and beat1 the opposite of beat0
		for (int i = 0; i < 16; i++) begin
			wr(4'h3, {9{i[3:0]}}, ~{9{i[3:0]}}, i[3:0], ~i[3:0]);
			rd(4'h3);
		end
		$display("test lanes done");
		wr(4'h0, 36'h0aaaaaaaa, 36'h055555555, 4'h0, 4'h0);
		wr(4'hf, 36'h0cafe0123, 36'h0beef4567, 4'h0, 4'h0);
		rd(4'h0);
		rd(4'hf);
		$display("test order done");
		oclk_run = 1'h0;
		rd(4'hf);
		oclk_run = 1'h1;
		$display("test held clocks done");
		do_reset();
		rd(4'h3);
		$display("test reset done");
		finish_test();
	end
endmodule

// ---- test/burst_link_monitor.sv ----
// wire-level checker for the link between the two ends
module burst_link_monitor #(
	parameter int DW = burst_sram_pkg::DEF_DW,
	parameter int AW = burst_sram_pkg::DEF_AW
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic k_true, // true-edge cycle marker
	input wire logic rd_n, // read select
	input wire logic wr_n, // write select
	input wire logic [AW-1:0] addr, // word-pair address
	input wire logic [DW-1:0] d, // write beat
	input wire logic [DW/burst_sram_pkg::LANE_W-1:0] lane_store_n, // lane enables
	input wire logic oclk_run, // output clocks run
	input wire logic [DW-1:0] q, // read beat
	input wire logic q_oe, // read beat driven
	input wire logic q_edge_true, // true output strobe
	input wire logic q_edge_comp // complementary output strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain, so clocking and reset are stated once
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	property p_k_tog; 1'b1 |=> (k_true != $past(k_true)); endproperty
	a_k_tog: assert property (p_k_tog) else $error("true edge marker stuck");
	property p_sel_true; (!rd_n || !wr_n) |-> k_true; endproperty
	a_sel_true: assert property (p_sel_true) else $error("select off true edge");
	// beat0 with the complementary strobe, beat1 with the true strobe
	property p_rd_launch;
		(k_true && !rd_n) |-> ##3 (q_oe && q_edge_comp == oclk_run)
			##1 (q_oe && q_edge_true == oclk_run);
	endproperty
	a_rd_launch: assert property (p_rd_launch) else $error("read beats late");
	property p_rd_two; (q_oe ##1 q_oe) |=> !q_oe; endproperty
	a_rd_two: assert property (p_rd_two) else $error("read burst over two beats");
	property p_q_float; !q_oe |-> (q == '0); endproperty
	a_q_float: assert property (p_q_float) else $error("read data not released");
	// strobes only matter once the held state has settled for a cycle
	property p_held; (!oclk_run && $past(oclk_run) == 1'b0) |-> !(q_edge_true || q_edge_comp);
	endproperty
	a_held: assert property (p_held) else $error("strobe with held clocks");
	property p_lanes_idle; (wr_n && $past(wr_n) == 1'b1) |-> (&lane_store_n); endproperty
	a_lanes_idle: assert property (p_lanes_idle) else $error("lane enable outside burst");
	property p_rd_cause; $rose(q_oe) |-> ($past(rd_n, 3) == 1'b0); endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("read beat without command");
endmodule
